// ### sab_pkg.sv
// Purpose: Shared constants and types of the serial autobuffer control block
// Assumes: 32-bit APB register bus, one clock, synchronous reset
// Notes:   Byte offsets are word aligned
package sab_pkg;
    localparam int unsigned SAB_AW    = 12;
    localparam int unsigned SAB_DW    = 32;
    localparam int unsigned SAB_SW    = 4;
    localparam int unsigned SAB_CW    = 16;
    localparam int unsigned SAB_LOW_W = 10;
    localparam int unsigned SAB_INT_W = 4;
    localparam int unsigned SAB_CNT_W = 8;

    localparam logic [SAB_AW-1:0] SAB_ADDR_CTRL_EXT   = 12'h000;
    localparam logic [SAB_AW-1:0] SAB_ADDR_INT_STATUS = 12'h004;
    localparam logic [SAB_AW-1:0] SAB_ADDR_INT_MASK   = 12'h008;
    localparam logic [SAB_AW-1:0] SAB_ADDR_CROSS_CNT  = 12'h00C;

    localparam logic [SAB_CW-1:0] SAB_CTRL_EXT_RESET = 16'h0003;

    localparam int unsigned SAB_BIT_RX_HALT = 15;
    localparam int unsigned SAB_BIT_RX_HALF = 14;
    localparam int unsigned SAB_BIT_RX_EN   = 13;
    localparam int unsigned SAB_BIT_TX_HALT = 12;
    localparam int unsigned SAB_BIT_TX_HALF = 11;
    localparam int unsigned SAB_BIT_TX_EN   = 10;

    localparam int unsigned SAB_INT_RX_HALF = 0;
    localparam int unsigned SAB_INT_TX_HALF = 1;
    localparam int unsigned SAB_INT_RX_STOP = 2;
    localparam int unsigned SAB_INT_TX_STOP = 3;

    localparam int unsigned SAB_CNT_RX_LSB = 0;
    localparam int unsigned SAB_CNT_TX_LSB = 8;

    localparam logic [SAB_INT_W-1:0] SAB_INT_RESET  = 4'h0;
    localparam logic [SAB_CNT_W-1:0] SAB_CNT_RESET  = 8'h00;
    localparam logic [SAB_CNT_W-1:0] SAB_CNT_STEP   = 8'h01;
    localparam logic [SAB_DW-1:0]    SAB_DATA_ZERO  = 32'h00000000;

    typedef enum logic [1:0] {
        SAB_BUS_IDLE = 2'b00,
        SAB_BUS_DONE = 2'b01
    } sab_bus_state_t;
endpackage

// ### sab_dir.sv
// Purpose: One direction of the autobuffer: enable, half flag, boundary events
// Assumes: Access and boundary inputs come from logic on the same clock
// Notes:   Accesses seen while disabled are ignored
module sab_dir
    import sab_pkg::*;
#(
    parameter int unsigned EN_BIT   = SAB_BIT_RX_EN,
    parameter int unsigned HALF_BIT = SAB_BIT_RX_HALF
) (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_wr,
    input  wire logic i_wr_enable,
    input  wire logic i_halt,
    input  wire logic i_access,
    input  wire logic i_boundary,
    input  wire logic i_second,
    output logic      o_enable,
    output logic      o_half,
    output logic      o_event,
    output logic      o_stop
);
    typedef struct packed {
        logic enable;
        logic half;
        logic event_p;
        logic stop;
    } sab_dir_state_t;

    sab_dir_state_t st_reg;
    sab_dir_state_t st_next;

    always_comb begin
        st_next         = st_reg;
        st_next.event_p = 1'b0;
        st_next.stop    = 1'b0;
        if (i_wr) begin
            st_next.enable = i_wr_enable;
        end
        // Halt at the boundary wins over a software write in the same cycle
        if (st_reg.enable && i_access && i_boundary) begin
            st_next.half    = i_second;
            st_next.event_p = 1'b1;
            if (i_halt) begin
                st_next.enable = 1'b0;
                st_next.stop   = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg.enable  <= SAB_CTRL_EXT_RESET[EN_BIT];
            st_reg.half    <= SAB_CTRL_EXT_RESET[HALF_BIT];
            st_reg.event_p <= 1'b0;
            st_reg.stop    <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_enable = st_reg.enable;
    assign o_half   = st_reg.half;
    assign o_event  = st_reg.event_p;
    assign o_stop   = st_reg.stop;
endmodule

// ### sab_irq.sv
// Purpose: Sticky interrupt status, mask and one level interrupt line
// Assumes: Clear bits are write-one-to-clear
// Notes:   A new event beats a clear in the same cycle
module sab_irq
    import sab_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_srst,
    input  wire logic [SAB_INT_W-1:0] i_event,
    input  wire logic                 i_clear_wr,
    input  wire logic [SAB_INT_W-1:0] i_clear_bits,
    input  wire logic                 i_mask_wr,
    input  wire logic [SAB_INT_W-1:0] i_mask_data,
    output logic      [SAB_INT_W-1:0] o_status,
    output logic      [SAB_INT_W-1:0] o_mask,
    output logic                      o_irq
);
    typedef struct packed {
        logic [SAB_INT_W-1:0] status;
        logic [SAB_INT_W-1:0] mask;
        logic                 irq;
    } sab_irq_state_t;

    sab_irq_state_t st_reg;
    sab_irq_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (i_clear_wr) begin
            st_next.status = st_reg.status & ~i_clear_bits;
        end
        st_next.status = st_next.status | i_event;
        if (i_mask_wr) begin
            st_next.mask = i_mask_data;
        end
        st_next.irq = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg.status <= SAB_INT_RESET;
            st_reg.mask   <= SAB_INT_RESET;
            st_reg.irq    <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_status = st_reg.status;
    assign o_mask   = st_reg.mask;
    assign o_irq    = st_reg.irq;
endmodule

// ### sab_ctrl.sv
// Purpose: Control extension register and autobuffer control of a buffered serial port
// Assumes: APB slave, one clock, the address arithmetic lives outside and reports
//          each buffer access with a boundary and half indication
// Notes:   Answers every access with one wait state
//
// Contract
// - Autobuffer control field sits in bits 15 to 10 of control extension register.
// - Reset loads the control extension register with 3; top six bits zero.
// - Receive halt set clears receive enable at the next half boundary.
// - Transmit halt set clears transmit enable at the next half boundary.
// - Read-only receive half flag shows which receive half was last filled.
// - Read-only transmit half flag shows which transmit half was last emptied.
// - Receive enable bit turns receive autobuffering on; clear means standard mode.
// - Transmit enable bit turns transmit autobuffering on; clear means standard mode.
// - Interrupt raised only when an access completes a first or second half; O_IRQ also rises when a mask write unmasks a pending status bit.
module sab_ctrl
    import sab_pkg::*;
(
    input  wire logic                 I_CORE_CLK,
    input  wire logic                 I_SRST,
    input  wire logic                 I_PSEL,
    input  wire logic                 I_PENABLE,
    input  wire logic                 I_PWRITE,
    input  wire logic [SAB_AW-1:0]    I_PADDR,
    input  wire logic [SAB_DW-1:0]    I_PWDATA,
    input  wire logic [SAB_SW-1:0]    I_PSTRB,
    output logic      [SAB_DW-1:0]    O_PRDATA,
    output logic                      O_PREADY,
    output logic                      O_PSLVERR,
    input  wire logic                 I_RX_ACCESS,
    input  wire logic                 I_RX_BOUNDARY,
    input  wire logic                 I_RX_SECOND_HALF,
    input  wire logic                 I_TX_ACCESS,
    input  wire logic                 I_TX_BOUNDARY,
    input  wire logic                 I_TX_SECOND_HALF,
    output logic                      O_RX_AUTOBUFFER_ENABLE,
    output logic                      O_TX_AUTOBUFFER_ENABLE,
    output logic                      O_RX_SERIAL_INTERRUPT,
    output logic                      O_TX_SERIAL_INTERRUPT,
    output logic      [SAB_LOW_W-1:0] O_SERIAL_PORT_CTRL,
    output logic                      O_IRQ
);
    typedef struct packed {
        sab_bus_state_t       bus_state;
        logic [SAB_DW-1:0]    prdata;
        logic                 pready;
        logic                 pslverr;
        logic                 rx_auto_halt;
        logic                 tx_auto_halt;
        logic [SAB_LOW_W-1:0] low_ctrl;
        logic [SAB_CNT_W-1:0] rx_count;
        logic [SAB_CNT_W-1:0] tx_count;
    } sab_ctrl_state_t;

    sab_ctrl_state_t st_reg;
    sab_ctrl_state_t st_next;

    // Byte lanes selected by the strobes, as a bit mask
    function automatic logic [SAB_DW-1:0] sab_lane_mask(input logic [SAB_SW-1:0] strb);
        logic [SAB_DW-1:0] m;
        m = SAB_DATA_ZERO;
        for (int i = 0; i < int'(SAB_SW); i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Merge write data into an old value through the byte strobes
    function automatic logic [SAB_DW-1:0] sab_merge(input logic [SAB_DW-1:0] old_v,
                                                    input logic [SAB_DW-1:0] data,
                                                    input logic [SAB_SW-1:0] strb);
        logic [SAB_DW-1:0] m;
        m = sab_lane_mask(strb);
        return (old_v & ~m) | (data & m);
    endfunction

    function automatic logic sab_known(input logic [SAB_AW-1:0] addr);
        return (addr == SAB_ADDR_CTRL_EXT) || (addr == SAB_ADDR_INT_STATUS) ||
               (addr == SAB_ADDR_INT_MASK) || (addr == SAB_ADDR_CROSS_CNT);
    endfunction

    logic                 rx_enable;
    logic                 tx_enable;
    logic                 rx_half;
    logic                 tx_half;
    logic                 rx_event;
    logic                 tx_event;
    logic                 rx_stop;
    logic                 tx_stop;
    logic [SAB_INT_W-1:0] int_status;
    logic [SAB_INT_W-1:0] int_mask;
    logic [SAB_INT_W-1:0] int_event;
    logic                 irq_line;
    logic [SAB_CW-1:0]    ctrl_img;
    logic [SAB_DW-1:0]    ctrl_wr_word;
    logic [SAB_DW-1:0]    mask_wr_word;
    logic [SAB_DW-1:0]    clear_word;
    logic                 wr_done;
    logic                 wr_ctrl;
    logic                 wr_status;
    logic                 wr_mask;
    logic                 wr_count;

    // Control field image in the upper six bits, serial port bits below
    always_comb begin
        ctrl_img                  = SAB_CTRL_EXT_RESET;
        ctrl_img[SAB_LOW_W-1:0]   = st_reg.low_ctrl;
        ctrl_img[SAB_BIT_RX_HALT] = st_reg.rx_auto_halt;
        ctrl_img[SAB_BIT_RX_HALF] = rx_half;
        ctrl_img[SAB_BIT_RX_EN]   = rx_enable;
        ctrl_img[SAB_BIT_TX_HALT] = st_reg.tx_auto_halt;
        ctrl_img[SAB_BIT_TX_HALF] = tx_half;
        ctrl_img[SAB_BIT_TX_EN]   = tx_enable;
    end

    // Writes take effect at the edge where the access completes
    assign wr_done   = (st_reg.bus_state == SAB_BUS_DONE) && I_PSEL && I_PENABLE &&
                       I_PWRITE && !st_reg.pslverr;
    assign wr_ctrl   = wr_done && (I_PADDR == SAB_ADDR_CTRL_EXT);
    assign wr_status = wr_done && (I_PADDR == SAB_ADDR_INT_STATUS);
    assign wr_mask   = wr_done && (I_PADDR == SAB_ADDR_INT_MASK);
    assign wr_count  = wr_done && (I_PADDR == SAB_ADDR_CROSS_CNT);

    assign ctrl_wr_word = sab_merge({{(SAB_DW-SAB_CW){1'b0}}, ctrl_img}, I_PWDATA, I_PSTRB);
    assign mask_wr_word = sab_merge({{(SAB_DW-SAB_INT_W){1'b0}}, int_mask}, I_PWDATA, I_PSTRB);
    assign clear_word   = I_PWDATA & sab_lane_mask(I_PSTRB);

    always_comb begin
        int_event                  = SAB_INT_RESET;
        int_event[SAB_INT_RX_HALF] = rx_event;
        int_event[SAB_INT_TX_HALF] = tx_event;
        int_event[SAB_INT_RX_STOP] = rx_stop;
        int_event[SAB_INT_TX_STOP] = tx_stop;
    end

    always_comb begin
        st_next        = st_reg;
        st_next.pready = 1'b0;
        case (st_reg.bus_state)
            SAB_BUS_IDLE: begin
                if (I_PSEL && I_PENABLE) begin
                    st_next.pready    = 1'b1;
                    st_next.pslverr   = !sab_known(I_PADDR);
                    st_next.bus_state = SAB_BUS_DONE;
                    st_next.prdata    = SAB_DATA_ZERO;
                    if (!I_PWRITE) begin
                        case (I_PADDR)
                            SAB_ADDR_CTRL_EXT: begin
                                st_next.prdata[SAB_CW-1:0] = ctrl_img;
                            end
                            SAB_ADDR_INT_STATUS: begin
                                st_next.prdata[SAB_INT_W-1:0] = int_status;
                            end
                            SAB_ADDR_INT_MASK: begin
                                st_next.prdata[SAB_INT_W-1:0] = int_mask;
                            end
                            SAB_ADDR_CROSS_CNT: begin
                                st_next.prdata[SAB_CNT_RX_LSB +: SAB_CNT_W] = st_reg.rx_count;
                                st_next.prdata[SAB_CNT_TX_LSB +: SAB_CNT_W] = st_reg.tx_count;
                            end
                            default: begin
                                st_next.prdata = SAB_DATA_ZERO;
                            end
                        endcase
                    end
                end
            end
            SAB_BUS_DONE: begin
                // Error flag is held until the answer is taken, then dropped
                st_next.bus_state = SAB_BUS_IDLE;
                st_next.pslverr   = 1'b0;
            end
            default: begin
                st_next.bus_state = SAB_BUS_IDLE;
                st_next.pslverr   = 1'b0;
            end
        endcase

        // Half flags are not taken from the write data: they stay hardware owned
        if (wr_ctrl) begin
            st_next.low_ctrl     = ctrl_wr_word[SAB_LOW_W-1:0];
            st_next.rx_auto_halt = ctrl_wr_word[SAB_BIT_RX_HALT];
            st_next.tx_auto_halt = ctrl_wr_word[SAB_BIT_TX_HALT];
        end

        // Boundary counters wrap; a crossing beats a clearing write
        if (wr_count) begin
            st_next.rx_count = SAB_CNT_RESET;
            st_next.tx_count = SAB_CNT_RESET;
        end
        if (rx_event) begin
            st_next.rx_count = st_next.rx_count + SAB_CNT_STEP;
        end
        if (tx_event) begin
            st_next.tx_count = st_next.tx_count + SAB_CNT_STEP;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            st_reg.bus_state    <= SAB_BUS_IDLE;
            st_reg.prdata       <= SAB_DATA_ZERO;
            st_reg.pready       <= 1'b0;
            st_reg.pslverr      <= 1'b0;
            st_reg.rx_auto_halt <= SAB_CTRL_EXT_RESET[SAB_BIT_RX_HALT];
            st_reg.tx_auto_halt <= SAB_CTRL_EXT_RESET[SAB_BIT_TX_HALT];
            st_reg.low_ctrl     <= SAB_CTRL_EXT_RESET[SAB_LOW_W-1:0];
            st_reg.rx_count     <= SAB_CNT_RESET;
            st_reg.tx_count     <= SAB_CNT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Receive side; enable and half flag reset from the control reset value
    sab_dir #(
        .EN_BIT   (SAB_BIT_RX_EN),
        .HALF_BIT (SAB_BIT_RX_HALF)
    ) u_rx_dir (
        .i_clk       (I_CORE_CLK),
        .i_srst      (I_SRST),
        .i_wr        (wr_ctrl),
        .i_wr_enable (ctrl_wr_word[SAB_BIT_RX_EN]),
        .i_halt      (st_reg.rx_auto_halt),
        .i_access    (I_RX_ACCESS),
        .i_boundary  (I_RX_BOUNDARY),
        .i_second    (I_RX_SECOND_HALF),
        .o_enable    (rx_enable),
        .o_half      (rx_half),
        .o_event     (rx_event),
        .o_stop      (rx_stop)
    );

    // Transmit side, same structure
    sab_dir #(
        .EN_BIT   (SAB_BIT_TX_EN),
        .HALF_BIT (SAB_BIT_TX_HALF)
    ) u_tx_dir (
        .i_clk       (I_CORE_CLK),
        .i_srst      (I_SRST),
        .i_wr        (wr_ctrl),
        .i_wr_enable (ctrl_wr_word[SAB_BIT_TX_EN]),
        .i_halt      (st_reg.tx_auto_halt),
        .i_access    (I_TX_ACCESS),
        .i_boundary  (I_TX_BOUNDARY),
        .i_second    (I_TX_SECOND_HALF),
        .o_enable    (tx_enable),
        .o_half      (tx_half),
        .o_event     (tx_event),
        .o_stop      (tx_stop)
    );

    sab_irq u_irq (
        .i_clk        (I_CORE_CLK),
        .i_srst       (I_SRST),
        .i_event      (int_event),
        .i_clear_wr   (wr_status),
        .i_clear_bits (clear_word[SAB_INT_W-1:0]),
        .i_mask_wr    (wr_mask),
        .i_mask_data  (mask_wr_word[SAB_INT_W-1:0]),
        .o_status     (int_status),
        .o_mask       (int_mask),
        .o_irq        (irq_line)
    );

    assign O_PRDATA               = st_reg.prdata;
    assign O_PREADY               = st_reg.pready;
    assign O_PSLVERR              = st_reg.pslverr;
    assign O_RX_AUTOBUFFER_ENABLE = rx_enable;
    assign O_TX_AUTOBUFFER_ENABLE = tx_enable;
    assign O_RX_SERIAL_INTERRUPT  = rx_event;
    assign O_TX_SERIAL_INTERRUPT  = tx_event;
    assign O_SERIAL_PORT_CTRL     = st_reg.low_ctrl;
    assign O_IRQ                  = irq_line;
endmodule

// ### sab_ctrl_asserts.sv
// Purpose: Port-level checks of the serial autobuffer control block
// Assumes: One clock, synchronous active-high reset
// Notes:   Halt and half bits are only visible through APB reads, so enable edges are tied to causes
module sab_ctrl_asserts
    import sab_pkg::*;
(
    input  wire logic                 I_CORE_CLK,
    input  wire logic                 I_SRST,
    input  wire logic                 I_PSEL,
    input  wire logic                 I_PWRITE,
    input  wire logic [SAB_AW-1:0]    I_PADDR,
    input  wire logic [SAB_DW-1:0]    I_PWDATA,
    input  wire logic                 I_RX_ACCESS,
    input  wire logic                 I_RX_BOUNDARY,
    input  wire logic                 I_TX_ACCESS,
    input  wire logic                 I_TX_BOUNDARY,
    input  wire logic [SAB_DW-1:0]    O_PRDATA,
    input  wire logic                 O_PREADY,
    input  wire logic                 O_RX_AUTOBUFFER_ENABLE,
    input  wire logic                 O_TX_AUTOBUFFER_ENABLE,
    input  wire logic                 O_RX_SERIAL_INTERRUPT,
    input  wire logic                 O_TX_SERIAL_INTERRUPT,
    input  wire logic [SAB_LOW_W-1:0] O_SERIAL_PORT_CTRL,
    input  wire logic                 O_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SRST);
    logic wr_done;
    logic ctrl_wr;
    logic rx_hit;
    logic tx_hit;
    assign wr_done = O_PREADY && I_PSEL && I_PWRITE;
    assign ctrl_wr = wr_done && (I_PADDR == SAB_ADDR_CTRL_EXT);
    assign rx_hit  = I_RX_ACCESS && I_RX_BOUNDARY && O_RX_AUTOBUFFER_ENABLE;
    assign tx_hit  = I_TX_ACCESS && I_TX_BOUNDARY && O_TX_AUTOBUFFER_ENABLE;

    property p_reset;
        $fell(I_SRST) |-> O_SERIAL_PORT_CTRL == 10'h003 && !O_RX_AUTOBUFFER_ENABLE && !O_TX_AUTOBUFFER_ENABLE;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");
    property p_rsvd;
        O_PREADY && I_PSEL && !I_PWRITE && I_PADDR == SAB_ADDR_CTRL_EXT |-> O_PRDATA[31:16] == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("upper read bits set");
    property p_rx_fire;
        rx_hit |=> O_RX_SERIAL_INTERRUPT;
    endproperty
    a_rx_fire: assert property (p_rx_fire) else $error("rx boundary pulse missing");
    property p_tx_fire;
        tx_hit |=> O_TX_SERIAL_INTERRUPT;
    endproperty
    a_tx_fire: assert property (p_tx_fire) else $error("tx boundary pulse missing");
    property p_rx_fall;
        $fell(O_RX_AUTOBUFFER_ENABLE) |-> $past(rx_hit || ctrl_wr);
    endproperty
    a_rx_fall: assert property (p_rx_fall) else $error("rx enable dropped without cause");
    property p_tx_fall;
        $fell(O_TX_AUTOBUFFER_ENABLE) |-> $past(tx_hit || ctrl_wr);
    endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("tx enable dropped without cause");
    property p_rx_rise;
        $rose(O_RX_AUTOBUFFER_ENABLE) |-> $past(ctrl_wr && I_PWDATA[SAB_BIT_RX_EN]);
    endproperty
    a_rx_rise: assert property (p_rx_rise) else $error("rx enable rose without write");
    property p_tx_rise;
        $rose(O_TX_AUTOBUFFER_ENABLE) |-> $past(ctrl_wr && I_PWDATA[SAB_BIT_TX_EN]);
    endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("tx enable rose without write");
    property p_irq_rise;
        // A mask write raises the line at its own completion edge
        $rose(O_IRQ) |-> $past(O_RX_SERIAL_INTERRUPT || O_TX_SERIAL_INTERRUPT || wr_done);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without event");

    c_rx_halt: cover property (rx_hit ##1 !O_RX_AUTOBUFFER_ENABLE);
    c_tx_pulse: cover property (tx_hit ##1 O_TX_SERIAL_INTERRUPT);
    c_irq: cover property ($rose(O_IRQ));
endmodule

bind sab_ctrl sab_ctrl_asserts u_asserts (
    .I_CORE_CLK, .I_SRST, .I_PSEL, .I_PWRITE, .I_PADDR, .I_PWDATA,
    .I_RX_ACCESS, .I_RX_BOUNDARY, .I_TX_ACCESS, .I_TX_BOUNDARY, .O_PRDATA, .O_PREADY,
    .O_RX_AUTOBUFFER_ENABLE, .O_TX_AUTOBUFFER_ENABLE, .O_RX_SERIAL_INTERRUPT,
    .O_TX_SERIAL_INTERRUPT, .O_SERIAL_PORT_CTRL, .O_IRQ
);

// ### sab_far_model.sv
// Purpose: Buffer address logic seen from the control block, one word per go pulse
// Assumes: Index 0 is receive, 1 is transmit
// Notes:   No access while disabled, as the real address logic makes no requests then
module sab_far_model #(
    parameter int unsigned BLK = 4
) (
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic [1:0] i_go,
    input  wire logic [1:0] i_en,
    output logic      [1:0] o_access,
    output logic      [1:0] o_boundary,
    output logic      [1:0] o_second
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned pos [2];
    always_ff @(posedge i_clk) begin
        for (int d = 0; d < 2; d++) begin
            o_access[d] <= 1'b0;
            // Qualifiers toggle when idle so a block reading them alone is caught
            o_boundary[d] <= ~o_boundary[d];
            o_second[d] <= ~o_second[d];
            if (i_srst) begin
                pos[d] <= 0;
                o_boundary[d] <= 1'b0;
                o_second[d] <= 1'b0;
            end else if (i_go[d] && i_en[d]) begin
                o_access[d] <= 1'b1;
                o_boundary[d] <= (pos[d] == BLK / 2 - 1) || (pos[d] == BLK - 1);
                o_second[d] <= (pos[d] == BLK - 1);
                pos[d] <= (pos[d] == BLK - 1) ? 0 : pos[d] + 1;
            end
        end
    end
endmodule

// ### tb_serial_autobuffer_control.sv
// Purpose: Self-checking bench of the serial autobuffer control block
// Assumes: Far-side buffer of four words, boundaries after words two and four
// Notes:   Both directions run the same sequence through one loop
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb_serial_autobuffer_control
    import sab_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk;
    logic              srst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [SAB_AW-1:0] paddr;
    logic [SAB_DW-1:0] pwdata;
    logic [SAB_DW-1:0] prdata;
    logic [SAB_DW-1:0] rd;
    logic [SAB_DW-1:0] en_m;
    logic [SAB_DW-1:0] half_m;
    logic [SAB_DW-1:0] halt_m;
    logic [SAB_DW-1:0] hb;
    logic [SAB_DW-1:0] sb;
    logic [3:0]        pstrb;
    logic              pready;
    logic              pslverr;
    logic              err;
    logic              rx_en;
    logic              tx_en;
    logic              rx_int;
    logic              tx_int;
    logic              irq;
    logic [1:0]        go;
    logic [1:0]        acc;
    logic [1:0]        bnd;
    logic [1:0]        sec;
    logic [9:0]        spc;
    int                bad_count;
    int                num_checks;
    int                ic [2];

    sab_ctrl u_dut (
        .I_CORE_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_RX_ACCESS(acc[0]), .I_RX_BOUNDARY(bnd[0]), .I_RX_SECOND_HALF(sec[0]),
        .I_TX_ACCESS(acc[1]), .I_TX_BOUNDARY(bnd[1]), .I_TX_SECOND_HALF(sec[1]),
        .O_RX_AUTOBUFFER_ENABLE(rx_en), .O_TX_AUTOBUFFER_ENABLE(tx_en), .O_RX_SERIAL_INTERRUPT(rx_int),
        .O_TX_SERIAL_INTERRUPT(tx_int), .O_SERIAL_PORT_CTRL(spc), .O_IRQ(irq)
    );
    sab_far_model #(.BLK(4)) u_far (
        .i_clk(clk), .i_srst(srst), .i_go(go), .i_en({tx_en, rx_en}),
        .o_access(acc), .o_boundary(bnd), .o_second(sec)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rx_int === 1'b1) ic[0]++;
        if (tx_int === 1'b1) ic[1]++;
    end

    task end_of_test;
        if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Holds the request until pready is sampled high, then takes data and releases
    task xfer(input logic w, input logic [SAB_AW-1:0] a, input logic [SAB_DW-1:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) `CHK(pready, 1'b1)
    endtask
    task wr(input logic [SAB_AW-1:0] a, input logic [SAB_DW-1:0] d);
        xfer(1'b1, a, d);
    endtask
    task chk(input logic [SAB_AW-1:0] a, input logic [SAB_DW-1:0] e);
        xfer(1'b0, a, SAB_DATA_ZERO);
        `CHK(rd, e)
    endtask
    task send(input int d, input int n);
        repeat (n) begin
            @(posedge clk);
            go[d] <= 1'b1;
            @(posedge clk);
            go[d] <= 1'b0;
        end
        repeat (4) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        `CHK(1'b0, 1'b1)
        end_of_test();
    end

    initial begin
        srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        pstrb = 4'hF; go = 2'b00; bad_count = 0; num_checks = 0; ic[0] = 0; ic[1] = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK(spc, 10'h003)
        chk(SAB_ADDR_CTRL_EXT, 32'h0000_0003);
        wr(SAB_ADDR_CTRL_EXT, 32'hFFFF_FFFF);
        chk(SAB_ADDR_CTRL_EXT, 32'h0000_B7FF);
        `CHK(spc, 10'h3FF)
        `CHK({rx_en, tx_en}, 2'b11)
        wr(SAB_ADDR_CTRL_EXT, 32'h0000_0003);
        // The write lands at the edge the task returns on; look one edge later
        @(posedge clk);
        `CHK({rx_en, tx_en}, 2'b00)
        xfer(1'b0, 12'h010, SAB_DATA_ZERO);
        `CHK({err, rd}, {1'b1, SAB_DATA_ZERO})
        for (int d = 0; d < 2; d++) begin
            en_m = 32'h1 << (d ? SAB_BIT_TX_EN : SAB_BIT_RX_EN);
            half_m = 32'h1 << (d ? SAB_BIT_TX_HALF : SAB_BIT_RX_HALF);
            halt_m = 32'h1 << (d ? SAB_BIT_TX_HALT : SAB_BIT_RX_HALT);
            hb = 32'h1 << (d ? SAB_INT_TX_HALF : SAB_INT_RX_HALF);
            sb = 32'h1 << (d ? SAB_INT_TX_STOP : SAB_INT_RX_STOP);
            wr(SAB_ADDR_INT_MASK, SAB_DATA_ZERO);
            wr(SAB_ADDR_CTRL_EXT, 32'h3 | en_m);
            send(d, 2);
            `CHK(ic[d], 1)
            chk(SAB_ADDR_CTRL_EXT, 32'h3 | en_m);
            chk(SAB_ADDR_INT_STATUS, hb);
            `CHK(irq, 1'b0)
            wr(SAB_ADDR_INT_MASK, 32'hF);
            repeat (3) @(posedge clk);
            `CHK(irq, 1'b1)
            wr(SAB_ADDR_INT_STATUS, 32'hF);
            repeat (3) @(posedge clk);
            `CHK(irq, 1'b0)
            send(d, 2);
            `CHK(ic[d], 2)
            chk(SAB_ADDR_CTRL_EXT, 32'h3 | en_m | half_m);
            wr(SAB_ADDR_CTRL_EXT, 32'h3 | en_m);
            chk(SAB_ADDR_CTRL_EXT, 32'h3 | en_m | half_m);
            wr(SAB_ADDR_INT_STATUS, 32'hF);
            wr(SAB_ADDR_CTRL_EXT, 32'h3 | en_m | halt_m);
            send(d, 1);
            `CHK(d ? tx_en : rx_en, 1'b1)
            send(d, 1);
            `CHK(d ? tx_en : rx_en, 1'b0)
            `CHK(ic[d], 3)
            chk(SAB_ADDR_CTRL_EXT, 32'h3 | halt_m);
            chk(SAB_ADDR_INT_STATUS, hb | sb);
            wr(SAB_ADDR_INT_STATUS, 32'hF);
            wr(SAB_ADDR_CTRL_EXT, 32'h3);
        end
        chk(SAB_ADDR_CROSS_CNT, 32'h0000_0303);
        wr(SAB_ADDR_CROSS_CNT, SAB_DATA_ZERO);
        chk(SAB_ADDR_CROSS_CNT, SAB_DATA_ZERO);
        end_of_test();
    end
endmodule
